// >>> hdl/alarm_regs_pkg.sv
// Package: register map, frame timing and carrier types for the alarm register bank
package alarm_regs_pkg;
  localparam int NUM_CHAN = 8;
  localparam logic [6:0] HYST_CH0_ADDR = 7'h15;
  localparam logic [6:0] LOW_UPPER_CH0_ADDR = 7'h18;
  localparam logic [6:0] LOW_LOWER_CH0_ADDR = 7'h19;
  localparam logic [6:0] CHAN_STRIDE = 7'h05;
  localparam logic [6:0] CMD_ECHO_ADDR = 7'h3F;
  localparam logic [7:0] LOW_UPPER_RESET = 8'h00;
  localparam logic [7:0] LOW_LOWER_RESET = 8'h00;
  localparam logic [7:0] HYST_RESET = 8'h00;
  localparam logic [7:0] CMD_ECHO_RESET = 8'h00;
  localparam logic [4:0] CMD_BITS = 5'h10;
  localparam logic [4:0] ECHO_START_FALL = 5'h10;
  localparam logic [4:0] ECHO_LAST_RISE = 5'h18;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } serial_in_t;

  typedef struct packed {
    logic [15:0] threshold;
    logic [7:0] hysteresis;
  } chan_alarm_t;
endpackage : alarm_regs_pkg

// >>> hdl/alarm_regs.sv
// Alarm low-threshold, hysteresis and command read-back registers behind the serial port
// Function
// - Per channel RW upper threshold byte, reset zero, channel 0 at 18h.
// - Per channel RW lower threshold byte, reset 00h, channel 0 at 19h.
// - Threshold is upper byte concatenated with lower byte; any byte value accepted.
// - Address 3Fh reads back command; read-only, resets to zero.
// - Read-back returns command executed in the previous frame.
// - Read-back shifted MSB first from the 16th falling clock edge.
// - First eight read-back bits carry the command's address and write bit; next eight are zero.
// - Per channel RW hysteresis register, reset zero, channel 0 at 15h.
`timescale 1ns/1ns
module alarm_regs (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire alarm_regs_pkg::serial_in_t ser_in,
  output logic sdo_out,
  output alarm_regs_pkg::chan_alarm_t [alarm_regs_pkg::NUM_CHAN-1:0] alarm_cfg_out
);
  import alarm_regs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD = 3'b010,
    ST_DATA = 3'b100
  } frame_st_t;

  // Two-flop synchronisers for the pins
  logic [2:0] sync1_r, sync2_r, prev_r;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1_r <= 3'b010;
      sync2_r <= 3'b010;
      prev_r <= 3'b010;
    end else begin
      sync1_r <= ser_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  logic sclk_s, csn_s, sdi_s, rise, fall;
  assign sclk_s = sync2_r[2];
  assign csn_s = sync2_r[1];
  assign sdi_s = sync2_r[0];
  assign rise = !csn_s && sclk_s && !prev_r[2];
  assign fall = !csn_s && !sclk_s && prev_r[2];

  function automatic logic [2:0] chan_of(input logic [6:0] a, input logic [6:0] base);
    logic [6:0] d;
    d = a - base;
    chan_of = 3'h0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (d == 7'(i * 5)) chan_of = 3'(i);
    end
  endfunction : chan_of

  function automatic logic hit(input logic [6:0] a, input logic [6:0] base);
    logic [6:0] d;
    d = a - base;
    hit = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (d == 7'(i * 5)) hit = 1'b1;
    end
  endfunction : hit

  frame_st_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt, last_cmd_r, last_cmd_nxt;
  logic [15:0] out_r, out_nxt;
  logic sdo_r, sdo_nxt;
  logic [7:0] upper_r [NUM_CHAN], upper_nxt [NUM_CHAN];
  logic [7:0] lower_r [NUM_CHAN], lower_nxt [NUM_CHAN];
  logic [7:0] hyst_r [NUM_CHAN], hyst_nxt [NUM_CHAN];

  always_comb begin
    logic [6:0] addr;
    logic wr;
    addr = sh_r[15:9];
    wr = sh_r[8];
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    last_cmd_nxt = last_cmd_r;
    out_nxt = out_r;
    sdo_nxt = sdo_r;
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    hyst_nxt = hyst_r;
    case (st_r)
      ST_IDLE: begin
        if (!csn_s) begin
          st_nxt = ST_CMD;
          cnt_nxt = 5'h00;
          sdo_nxt = 1'b0;
        end
      end
      ST_CMD, ST_DATA: begin
        if (csn_s) begin
          st_nxt = ST_IDLE;
          // Output returns low between frames, even after a cut frame
          sdo_nxt = 1'b0;
          // Frame ends: a fully shifted command becomes the previous command
          if (cnt_r >= CMD_BITS) last_cmd_nxt = sh_r;
        end else begin
          if (rise && cnt_r != 5'h1F) begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r < CMD_BITS) sh_nxt = {sh_r[14:0], sdi_s};
          end
          if (rise && cnt_r == CMD_BITS - 5'h01) st_nxt = ST_DATA;
          if (st_r == ST_DATA && fall && cnt_r == ECHO_START_FALL) begin
            out_nxt = 16'h0000;
            if (addr == CMD_ECHO_ADDR && !wr) begin
              out_nxt = {last_cmd_r[15:8], 8'h00};
            end else if (hit(addr, LOW_UPPER_CH0_ADDR)) begin
              out_nxt = {upper_r[chan_of(addr, LOW_UPPER_CH0_ADDR)], 8'h00};
            end else if (hit(addr, LOW_LOWER_CH0_ADDR)) begin
              out_nxt = {lower_r[chan_of(addr, LOW_LOWER_CH0_ADDR)], 8'h00};
            end else if (hit(addr, HYST_CH0_ADDR)) begin
              out_nxt = {hyst_r[chan_of(addr, HYST_CH0_ADDR)], 8'h00};
            end
            if (wr) begin
              if (hit(addr, LOW_UPPER_CH0_ADDR))
                upper_nxt[chan_of(addr, LOW_UPPER_CH0_ADDR)] = sh_r[7:0];
              if (hit(addr, LOW_LOWER_CH0_ADDR))
                lower_nxt[chan_of(addr, LOW_LOWER_CH0_ADDR)] = sh_r[7:0];
              if (hit(addr, HYST_CH0_ADDR))
                hyst_nxt[chan_of(addr, HYST_CH0_ADDR)] = sh_r[7:0];
            end
            sdo_nxt = out_nxt[15];
            out_nxt = {out_nxt[14:0], 1'b0};
          end else if (st_r == ST_DATA && fall && cnt_r > ECHO_START_FALL) begin
            sdo_nxt = out_r[15];
            out_nxt = {out_r[14:0], 1'b0};
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      last_cmd_r <= {CMD_ECHO_RESET, 8'h00};
      out_r <= 16'h0000;
      sdo_r <= 1'b0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        upper_r[i] <= LOW_UPPER_RESET;
        lower_r[i] <= LOW_LOWER_RESET;
        hyst_r[i] <= HYST_RESET;
      end
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      last_cmd_r <= last_cmd_nxt;
      out_r <= out_nxt;
      sdo_r <= sdo_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      hyst_r <= hyst_nxt;
    end
  end

  assign sdo_out = sdo_r;
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      alarm_cfg_out[i].threshold = {upper_r[i], lower_r[i]};
      alarm_cfg_out[i].hysteresis = hyst_r[i];
    end
  end

  // Assertions
  // Command execution point: the 16th falling serial clock edge of a frame
  logic exec_pt;
  assign exec_pt = st_r == ST_DATA && fall && cnt_r == ECHO_START_FALL;

  a_echo_low_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exec_pt && sh_r[15:8] == {CMD_ECHO_ADDR, 1'b0}
    |=> sdo_r == last_cmd_r[15] && out_r[8:0] == 9'h000)
    else $error("read-back low byte not zero");
  a_thr_concat: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exec_pt && sh_r[15:8] == {LOW_LOWER_CH0_ADDR, 1'b1}
    |=> alarm_cfg_out[0].threshold == {$past(upper_r[0]), $past(sh_r[7:0])})
    else $error("threshold not formed from both bytes");
  a_upper_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exec_pt && sh_r[15:8] == {LOW_UPPER_CH0_ADDR, 1'b1}
    |=> upper_r[0] == $past(sh_r[7:0]))
    else $error("upper threshold write lost");
  a_thr_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r == ST_IDLE |=> $stable(upper_r[0]) && $stable(lower_r[0]))
    else $error("threshold changed between frames");
  a_lower_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !fall |=> $stable(lower_r[1]))
    else $error("lower byte changed without a clock fall");
  a_hyst_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    exec_pt && sh_r[15:8] == {HYST_CH0_ADDR + CHAN_STRIDE, 1'b1}
    |=> hyst_r[1] == $past(sh_r[7:0]))
    else $error("hysteresis write lost");
  a_hyst_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !fall |=> $stable(hyst_r[0]))
    else $error("hysteresis changed without a clock fall");
  a_sdo_early: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r != ST_DATA |-> !sdo_out)
    else $error("serial output not idle outside data phase");
  a_msb_first: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r == ST_DATA && fall && cnt_r > ECHO_START_FALL |=> sdo_r == $past(out_r[15]))
    else $error("serial output not shifted msb first");
  a_echo_update: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st_r != ST_IDLE && csn_s && cnt_r >= CMD_BITS |=> last_cmd_r == $past(sh_r))
    else $error("previous command not captured");
  a_echo_ro: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(st_r != ST_IDLE && csn_s) |=> $stable(last_cmd_r))
    else $error("read-back register changed inside a frame");
  c_short_frame: cover property (@(posedge clk_in) st_r == ST_DATA && csn_s
    && cnt_r == ECHO_LAST_RISE);
  c_frame: cover property (@(posedge clk_in) st_r == ST_DATA ##1 st_r == ST_IDLE);
  c_echo: cover property (@(posedge clk_in) fall && cnt_r == ECHO_START_FALL
    && sh_r[15:9] == CMD_ECHO_ADDR);
  c_write: cover property (@(posedge clk_in) upper_r[0] != LOW_UPPER_RESET);
endmodule : alarm_regs

// >>> bench/host_model.sv
// Host side of the serial port: frames commands and captures the returned word
`timescale 1ns/1ns
module host_model
  import alarm_regs_pkg::*;
(
  input wire logic clk_in,
  output serial_in_t ser_out,
  input wire logic sdo_in,
  output logic [15:0] word_out,
  output logic done_out
);
  initial begin
    ser_out = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    word_out = 16'h0000;
    done_out = 1'b0;
  end
  task automatic half;
    repeat (8) @(negedge clk_in);
  endtask : half
  // Serial clock runs only inside the frame
  task automatic frame(input logic [15:0] cmd, input int nclk);
    logic [15:0] rd;
    rd = 16'h0000;
    ser_out.cs_n <= 1'b0;
    for (int i = 0; i < nclk; i++) begin
      ser_out.sdi <= (i < 16) ? cmd[15-i] : ~ser_out.sdi;
      half();
      ser_out.sclk <= 1'b1;
      if (i >= 16) rd[31-i] = sdo_in;
      half();
      ser_out.sclk <= 1'b0;
    end
    half();
    ser_out.cs_n <= 1'b1;
    ser_out.sdi <= ~ser_out.sdi;
    word_out <= rd;
    done_out <= 1'b1;
    @(negedge clk_in);
    done_out <= 1'b0;
    repeat (6) @(negedge clk_in);
  endtask : frame
endmodule : host_model

// >>> bench/alarm_low_threshold_and_cmd_readback_tb_top.sv
// Testbench: host frames into the alarm register bank, results checked from a queue
`timescale 1ns/1ns
module alarm_low_threshold_and_cmd_readback_tb_top;
  import alarm_regs_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  serial_in_t ser;
  logic sdo;
  chan_alarm_t [NUM_CHAN-1:0] cfg;
  logic [15:0] word;
  logic done;
  logic [31:0] notes [$];
  logic [31:0] note;
  logic [23:0] model [NUM_CHAN];
  logic [7:0] u, l, h;
  logic [6:0] a;
  int fail_count = 0;
  int comparisons = 0;
  alarm_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ser_in(ser), .sdo_out(sdo),
    .alarm_cfg_out(cfg));
  host_model i_host (.clk_in(clk_in), .ser_out(ser), .sdo_in(sdo), .word_out(word),
    .done_out(done));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // Note the masked expected word, then run the frame
  task automatic xfer(input logic [6:0] ad, input logic w, input logic [7:0] d,
    input logic [15:0] m, input logic [15:0] e, input int n);
    notes.push_back({m, e});
    i_host.frame({ad, w, d}, n);
  endtask : xfer
  always @(posedge clk_in) begin
    if (done === 1'b1) begin
      note = notes.pop_front();
      check_word(word & note[31:16], note[15:0]);
    end
  end
  initial begin
    void'($urandom(75));
    repeat (6) @(negedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    for (int c = 0; c < NUM_CHAN; c++) check(cfg[c], 24'h000000);
    xfer(CMD_ECHO_ADDR, 1'b0, 8'h00, 16'hFFFF, 16'h0000, 32);
    for (int c = 0; c < NUM_CHAN; c++) begin
      u = 8'($urandom);
      l = 8'($urandom);
      h = 8'($urandom);
      a = LOW_UPPER_CH0_ADDR + CHAN_STRIDE * 7'(c);
      xfer(a, 1'b1, u, 16'h0000, 16'h0000, 32);
      xfer(a + 7'h01, 1'b1, l, 16'h0000, 16'h0000, 32);
      xfer(HYST_CH0_ADDR + CHAN_STRIDE * 7'(c), 1'b1, h, 16'h0000, 16'h0000, 32);
      model[c] = {u, l, h};
      check(cfg[c], model[c]);
      xfer(a + 7'h01, 1'b0, 8'h00, 16'hFF00, {l, 8'h00}, 32);
      xfer(HYST_CH0_ADDR + CHAN_STRIDE * 7'(c), 1'b0, 8'h00, 16'hFF00, {h, 8'h00}, 32);
      xfer(a, 1'b0, 8'h00, 16'hFF00, {u, 8'h00}, 32);
      xfer(CMD_ECHO_ADDR, 1'b0, 8'h00, 16'hFFFF, {a, 1'b0, 8'h00}, 32);
    end
    xfer(CMD_ECHO_ADDR, 1'b1, 8'hA5, 16'h0000, 16'h0000, 32);
    xfer(7'h7E, 1'b1, 8'h5A, 16'h0000, 16'h0000, 32);
    xfer(CMD_ECHO_ADDR, 1'b0, 8'h00, 16'hFF00, {7'h7E, 1'b1, 8'h00}, int'(ECHO_LAST_RISE));
    xfer(CMD_ECHO_ADDR, 1'b0, 8'h00, 16'hFFFF, {CMD_ECHO_ADDR, 1'b0, 8'h00}, 32);
    for (int c = 0; c < NUM_CHAN; c++) check(cfg[c], model[c]);
    repeat (20) @(negedge clk_in);
    tally_and_finish();
  end
  initial begin
    #600000;
    fail_count++;
    tally_and_finish();
  end
endmodule : alarm_low_threshold_and_cmd_readback_tb_top
